// File: rtl/phys_filter_pkg.sv
// Package: offsets, field positions, reset values and encodings of the physical request node filter
package phys_filter_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [11:0] OFF_FILT_HIGH_SET  = 12'h110;
    localparam logic [11:0] OFF_FILT_HIGH_CLR  = 12'h114;
    localparam logic [11:0] OFF_FILT_LOW_SET   = 12'h118;
    localparam logic [11:0] OFF_FILT_LOW_CLR   = 12'h11C;
    localparam logic [11:0] OFF_UPPER_BOUND    = 12'h120;
    localparam logic [11:0] OFF_ROUTE_STATUS   = 12'h124;
    localparam logic [11:0] OFF_ROUTE_CONTROL  = 12'h128;

    // ****************************************************************
    // Reset values and fields
    // ****************************************************************
    localparam logic [31:0] FILT_LOW_RESET     = 32'h00000000;
    localparam logic [31:0] FILT_HIGH_RESET    = 32'h00000000;
    localparam logic [31:0] UPPER_BOUND_VALUE  = 32'h00000000;
    localparam logic [31:0] UNMAPPED_READ      = 32'h00000000;
    localparam logic [9:0]  LOCAL_BUS_RESET    = 10'h3FF;
    localparam int          REMOTE_BUS_BIT     = 31;
    localparam int          HIGH_NODE_BASE     = 32;
    localparam logic [5:0]  NODE_LAST          = 6'h3E;
    localparam int          CTL_LOCAL_BUS_LSB  = 0;
    localparam int          STS_PHYS_CNT_LSB   = 0;
    localparam int          STS_ASYNC_CNT_LSB  = 8;
    localparam int          STS_DROP_CNT_LSB   = 16;
    localparam int          STS_BUSY_BIT       = 24;
    localparam int          STS_CNT_W          = 8;

    // ****************************************************************
    // Routing outcomes
    // ****************************************************************
    typedef enum logic [1:0] {
        ROUTE_PHYS  = 2'b00,
        ROUTE_ASYNC = 2'b01,
        ROUTE_DROP  = 2'b10
    } route_e;

endpackage

// File: rtl/rsc_word.sv
// One read/set/clear register word with a set alias and a clear alias
`timescale 1ns/1ps
module rsc_word
    import phys_filter_pkg::*;
#(
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    input  wire logic        i_clk,     // System clock
    input  wire logic        i_rst_n,   // Synchronous reset, active low
    input  wire logic        i_set,     // Write to the set alias
    input  wire logic        i_clr,     // Write to the clear alias
    input  wire logic [31:0] i_wdata,   // Write data, ones select bits
    output logic      [31:0] o_value    // Stored word
);

    typedef struct packed {
        logic [31:0] word;
    } rsc_state_s;

    rsc_state_s state_ff;
    rsc_state_s nxt_state;

    // Ones set or clear; zeros leave bits alone
    always_comb begin
        nxt_state = state_ff;
        if (i_set) begin
            nxt_state.word = state_ff.word | i_wdata;
        end else if (i_clr) begin
            nxt_state.word = state_ff.word & ~i_wdata;
        end
    end

    // Register, cleared at reset so no node is enabled
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff.word <= RESET_VALUE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_value = state_ff.word;

endmodule

// File: rtl/route_counter.sv
// Saturating event counter for routing statistics
`timescale 1ns/1ps
module route_counter
    import phys_filter_pkg::*;
(
    input  wire logic                 i_clk,    // System clock
    input  wire logic                 i_rst_n,  // Synchronous reset, active low
    input  wire logic                 i_inc,    // Count one event
    input  wire logic                 i_clear,  // Zero the count
    output logic      [STS_CNT_W-1:0] o_count   // Current count
);

    typedef struct packed {
        logic [STS_CNT_W-1:0] cnt;
    } cnt_state_s;

    cnt_state_s state_ff;
    cnt_state_s nxt_state;

    // Saturate rather than wrap so software never misreads a small count; increment with clear leaves a count of one
    always_comb begin
        nxt_state = state_ff;
        if (i_clear) begin
            nxt_state.cnt = '0;
        end
        // A clear at saturation must still let the new event count as one
        if (i_inc && (i_clear || state_ff.cnt != {STS_CNT_W{1'b1}})) begin
            nxt_state.cnt = i_clear ? STS_CNT_W'(1) : STS_CNT_W'(state_ff.cnt + 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff.cnt <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_count = state_ff.cnt;

endmodule

// File: rtl/physical_request_node_filter.sv
// Physical request node filter: filter registers and per-request routing decision
// Contract
// - Low word bit n routes local node n physical requests to physical context.
// - High word bits 30..0 enable local nodes 62..32, node equals bit plus 32.
// - Low word covers only node identifiers 0 to 31.
// - Physical filter check happens only after the async filter check passed; remote-bus requests skip the async check and bit 31 alone decides.
// - Clear filter bit sends the request to the async request receive context.
// - Low word has set alias 118h, clear alias 11Ch, both read stored value.
// - All filter bits reset to zero.
// - Upper bound register at 120h ignores writes and reads zero.
// - High bit 31 accepts non-local bus requests; clear means not acknowledged.
// - Per-node comparison applies only when source is on the local bus.
// - High word has set alias 110h and clear alias 114h.
`timescale 1ns/1ps
module physical_request_node_filter
    import phys_filter_pkg::*;
(
    input  wire logic        i_clk,             // System clock, 40 MHz
    input  wire logic        i_rst_n,           // Synchronous reset, active low
    // Register port
    input  wire logic [11:0] i_addr,            // Byte address
    input  wire logic [31:0] i_wdata,           // Write data
    input  wire logic        i_wr,              // Write strobe
    input  wire logic        i_rd,              // Read strobe
    output logic      [31:0] o_rdata,           // Read data, cycle after strobe
    // Request side
    input  wire logic        i_req_valid,       // Physical request to route, one cycle
    input  wire logic [15:0] i_req_src_id,      // Source ID: bus[15:6], node[5:0]
    input  wire logic        i_req_async_ok,    // Async filter already passed
    output logic             o_route_valid,     // Decision valid, one cycle
    output logic             o_route_phys,      // Serve by physical request context
    output logic             o_route_async,     // Serve by async request receive context
    output logic             o_route_drop,      // Do not acknowledge
    output logic      [15:0] o_route_src_id,    // Source ID of the decision
    // Filter word view
    output logic      [31:0] o_node_phys_enable_low,  // Low filter word
    output logic      [31:0] o_node_phys_enable_high  // High filter word
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0] rdata;
        logic        route_valid;
        route_e      route;
        logic [15:0] src_id;
        logic [9:0]  local_bus;
    } top_state_s;

    top_state_s state_ff;
    top_state_s nxt_state;

    logic [31:0] filt_low;
    logic [31:0] filt_high;
    logic        wr_low_set;
    logic        wr_low_clr;
    logic        wr_high_set;
    logic        wr_high_clr;
    logic        wr_ctl;
    logic        stat_clear;
    logic [STS_CNT_W-1:0] cnt_phys;
    logic [STS_CNT_W-1:0] cnt_async;
    logic [STS_CNT_W-1:0] cnt_drop;
    logic [9:0]  src_bus;
    logic [5:0]  src_node;
    logic        node_enabled;
    logic        remote_bus_accept;
    route_e      route_now;

    // ****************************************************************
    // Write decode
    // ****************************************************************
    // Writes to the upper bound offset decode to nothing and so are ignored
    assign wr_low_set  = i_wr && (i_addr == OFF_FILT_LOW_SET);
    assign wr_low_clr  = i_wr && (i_addr == OFF_FILT_LOW_CLR);
    assign wr_high_set = i_wr && (i_addr == OFF_FILT_HIGH_SET);
    assign wr_high_clr = i_wr && (i_addr == OFF_FILT_HIGH_CLR);
    assign wr_ctl      = i_wr && (i_addr == OFF_ROUTE_CONTROL);
    // Any write to the status offset zeroes the counters
    assign stat_clear  = i_wr && (i_addr == OFF_ROUTE_STATUS);

    // ****************************************************************
    // Filter words
    // ****************************************************************
    rsc_word #(
        .RESET_VALUE (FILT_LOW_RESET)
    ) u_filt_low (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_set   (wr_low_set),
        .i_clr   (wr_low_clr),
        .i_wdata (i_wdata),
        .o_value (filt_low)
    );

    rsc_word #(
        .RESET_VALUE (FILT_HIGH_RESET)
    ) u_filt_high (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_set   (wr_high_set),
        .i_clr   (wr_high_clr),
        .i_wdata (i_wdata),
        .o_value (filt_high)
    );

    // ****************************************************************
    // Routing decision
    // ****************************************************************
    assign src_bus           = i_req_src_id[15:6];
    assign src_node          = i_req_src_id[5:0];
    assign remote_bus_accept = filt_high[REMOTE_BUS_BIT];

    // Node 63 is the broadcast ID and has no enable bit
    always_comb begin
        node_enabled = 1'b0;
        if (src_node < 6'(HIGH_NODE_BASE)) begin
            node_enabled = filt_low[src_node[4:0]];
        end else if (src_node <= NODE_LAST) begin
            node_enabled = filt_high[5'(src_node - 6'(HIGH_NODE_BASE))];
        end
    end

    // The local bus check comes first; remote sources bypass per-node bits
    always_comb begin
        route_now = ROUTE_ASYNC;
        if (src_bus != state_ff.local_bus) begin
            route_now = remote_bus_accept ? ROUTE_PHYS : ROUTE_DROP;
        end else if (!i_req_async_ok) begin
            route_now = ROUTE_DROP;
        end else if (node_enabled) begin
            route_now = ROUTE_PHYS;
        end else begin
            route_now = ROUTE_ASYNC;
        end
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    route_counter u_cnt_phys (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_inc   (i_req_valid && route_now == ROUTE_PHYS),
        .i_clear (stat_clear),
        .o_count (cnt_phys)
    );

    route_counter u_cnt_async (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_inc   (i_req_valid && route_now == ROUTE_ASYNC),
        .i_clear (stat_clear),
        .o_count (cnt_async)
    );

    route_counter u_cnt_drop (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_inc   (i_req_valid && route_now == ROUTE_DROP),
        .i_clear (stat_clear),
        .o_count (cnt_drop)
    );

    // ****************************************************************
    // Next state: decision capture, control, read data
    // ****************************************************************
    // The decision is sampled from the filter value before any write in the same
    // cycle lands, so a request in flight keeps the old setting.
    always_comb begin
        nxt_state             = state_ff;
        nxt_state.route_valid = i_req_valid;
        if (i_req_valid) begin
            nxt_state.route  = route_now;
            nxt_state.src_id = i_req_src_id;
        end
        if (wr_ctl) begin
            nxt_state.local_bus = i_wdata[CTL_LOCAL_BUS_LSB +: 10];
        end
        nxt_state.rdata = state_ff.rdata;
        if (i_rd) begin
            case (i_addr)
                OFF_FILT_LOW_SET,
                OFF_FILT_LOW_CLR:  nxt_state.rdata = filt_low;
                OFF_FILT_HIGH_SET,
                OFF_FILT_HIGH_CLR: nxt_state.rdata = filt_high;
                OFF_UPPER_BOUND:   nxt_state.rdata = UPPER_BOUND_VALUE;
                OFF_ROUTE_CONTROL: nxt_state.rdata = {22'h0, state_ff.local_bus};
                OFF_ROUTE_STATUS: begin
                    nxt_state.rdata = '0;
                    nxt_state.rdata[STS_PHYS_CNT_LSB  +: STS_CNT_W] = cnt_phys;
                    nxt_state.rdata[STS_ASYNC_CNT_LSB +: STS_CNT_W] = cnt_async;
                    nxt_state.rdata[STS_DROP_CNT_LSB  +: STS_CNT_W] = cnt_drop;
                    nxt_state.rdata[STS_BUSY_BIT]                   = state_ff.route_valid;
                end
                default:           nxt_state.rdata = UNMAPPED_READ;
            endcase
        end
    end

    // Register the whole state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff.rdata       <= '0;
            state_ff.route_valid <= 1'b0;
            state_ff.route       <= ROUTE_ASYNC;
            state_ff.src_id      <= '0;
            state_ff.local_bus   <= LOCAL_BUS_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_rdata                 = state_ff.rdata;
    assign o_route_valid           = state_ff.route_valid;
    assign o_route_phys            = state_ff.route_valid && state_ff.route == ROUTE_PHYS;
    assign o_route_async           = state_ff.route_valid && state_ff.route == ROUTE_ASYNC;
    assign o_route_drop            = state_ff.route_valid && state_ff.route == ROUTE_DROP;
    assign o_route_src_id          = state_ff.src_id;
    assign o_node_phys_enable_low  = filt_low;
    assign o_node_phys_enable_high = filt_high;

endmodule

// File: testbench/phys_filter_props.sv
// Checker: port-level properties of the physical request node filter
`timescale 1ns/1ps
module phys_filter_props
    import phys_filter_pkg::*;
(
    input wire logic        i_clk,                   // Clock
    input wire logic        i_rst_n,                 // Reset
    input wire logic [11:0] i_addr,                  // Address
    input wire logic [31:0] i_wdata,                 // Write data
    input wire logic        i_wr,                    // Write strobe
    input wire logic        i_rd,                    // Read strobe
    input wire logic [31:0] o_rdata,                 // Read data
    input wire logic        i_req_valid,             // Request
    input wire logic [15:0] i_req_src_id,            // Source
    input wire logic        i_req_async_ok,          // Async verdict
    input wire logic        o_route_valid,           // Decision
    input wire logic        o_route_phys,            // Physical
    input wire logic        o_route_async,           // Async
    input wire logic        o_route_drop,            // Drop
    input wire logic [15:0] o_route_src_id,          // Decision source
    input wire logic [31:0] o_node_phys_enable_low,  // Low word
    input wire logic [31:0] o_node_phys_enable_high  // High word
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Decision timing and shape
    route_one_cycle_a: assert property (i_req_valid |=> o_route_valid)
        else $error("decision missing");
    route_quiet_a: assert property (!i_req_valid |=> !(o_route_phys | o_route_async | o_route_drop))
        else $error("decision without request");
    route_onehot_a: assert property (o_route_valid |-> $onehot({o_route_phys, o_route_async, o_route_drop}))
        else $error("decision not one-hot");
    route_src_a: assert property (i_req_valid |=> o_route_src_id == $past(i_req_src_id))
        else $error("decision source wrong");
    // Routing against the filter words; remote acceptance excluded
    async_fail_drop_a: assert property (i_req_valid && !i_req_async_ok && !o_node_phys_enable_high[31]
        |=> o_route_drop) else $error("async reject not dropped");
    low_off_a: assert property (i_req_valid && !i_req_src_id[5] && !o_node_phys_enable_high[31]
        && !o_node_phys_enable_low[i_req_src_id[4:0]] |=> !o_route_phys) else $error("low bit ignored");
    high_off_a: assert property (i_req_valid && i_req_src_id[5] && !o_node_phys_enable_high[31]
        && !o_node_phys_enable_high[i_req_src_id[4:0]] |=> !o_route_phys) else $error("high bit ignored");
    // Set and clear aliases
    low_set_a: assert property (i_wr && i_addr == OFF_FILT_LOW_SET |=> o_node_phys_enable_low ==
        ($past(o_node_phys_enable_low) | $past(i_wdata))) else $error("low set wrong");
    low_clr_a: assert property (i_wr && i_addr == OFF_FILT_LOW_CLR |=> o_node_phys_enable_low ==
        ($past(o_node_phys_enable_low) & ~$past(i_wdata))) else $error("low clear wrong");
    high_set_a: assert property (i_wr && i_addr == OFF_FILT_HIGH_SET |=> o_node_phys_enable_high ==
        ($past(o_node_phys_enable_high) | $past(i_wdata))) else $error("high set wrong");
    high_clr_a: assert property (i_wr && i_addr == OFF_FILT_HIGH_CLR |=> o_node_phys_enable_high ==
        ($past(o_node_phys_enable_high) & ~$past(i_wdata))) else $error("high clear wrong");
    filt_hold_a: assert property (!i_wr |=> $stable(o_node_phys_enable_low) && $stable(o_node_phys_enable_high))
        else $error("filter changed without write");
    // Reads and reset
    upper_zero_a: assert property (i_rd && i_addr == OFF_UPPER_BOUND |=> o_rdata == UPPER_BOUND_VALUE)
        else $error("upper bound not zero");
    low_read_a: assert property (i_rd && (i_addr == OFF_FILT_LOW_SET || i_addr == OFF_FILT_LOW_CLR)
        |=> o_rdata == $past(o_node_phys_enable_low)) else $error("low alias read wrong");
    reset_zero_a: assert property ($rose(i_rst_n) |-> o_node_phys_enable_low == FILT_LOW_RESET
        && o_node_phys_enable_high == FILT_HIGH_RESET) else $error("filter not reset");
    // Main scenarios reached
    phys_seen_c: cover property (i_req_valid ##1 o_route_phys);
    async_seen_c: cover property (i_req_valid ##1 o_route_async);
    drop_seen_c: cover property (i_req_valid ##1 o_route_drop);
endmodule

// File: testbench/remote_node_model.sv
// Partner model: remote node that offers physical requests to the filter
`timescale 1ns/1ps
module remote_node_model (
    input  wire logic        i_clk,          // System clock
    output logic             o_req_valid,    // Request strobe
    output logic      [15:0] o_req_src_id,   // Bus and node of the source
    output logic             o_req_async_ok  // Async filter verdict
);
    // ****************************************************************
    // Request driver
    // ****************************************************************
    // Quiet lines at time zero
    initial begin
        o_req_valid    = 1'b0;
        o_req_src_id   = 16'h0000;
        o_req_async_ok = 1'b0;
    end
    // One request per call; back-to-back calls keep the strobe high
    task automatic send(input logic [9:0] b, input logic [5:0] n, input logic ok);
        o_req_valid    <= 1'b1;
        o_req_src_id   <= {b, n};
        o_req_async_ok <= ok;
        @(posedge i_clk);
    endtask
    // Released lines invert so a stale source can never look current
    task automatic idle();
        o_req_valid    <= 1'b0;
        o_req_src_id   <= ~o_req_src_id;
        o_req_async_ok <= ~o_req_async_ok;
        @(posedge i_clk);
    endtask
endmodule

// File: testbench/physical_request_node_filter_tb.sv
// Testbench: register access and request routing of the physical request node filter
`timescale 1ns/1ps
module physical_request_node_filter_tb
    import phys_filter_pkg::*;
;
    // ****************************************************************
    // Signals, design and partner
    // ****************************************************************
    logic        i_clk, i_rst_n, i_wr, i_rd, i_req_valid, i_req_async_ok;
    logic        o_route_valid, o_route_phys, o_route_async, o_route_drop;
    logic [11:0] i_addr;
    logic [15:0] i_req_src_id, o_route_src_id;
    logic [31:0] i_wdata, o_rdata, o_node_phys_enable_low, o_node_phys_enable_high, lo, hi;
    logic [9:0]  lb;
    int          mismatches, samples_checked, cycles;
    always #12.5 i_clk = ~i_clk;
    physical_request_node_filter i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req_valid(i_req_valid), .i_req_src_id(i_req_src_id),
        .i_req_async_ok(i_req_async_ok), .o_route_valid(o_route_valid), .o_route_phys(o_route_phys),
        .o_route_async(o_route_async), .o_route_drop(o_route_drop), .o_route_src_id(o_route_src_id),
        .o_node_phys_enable_low(o_node_phys_enable_low), .o_node_phys_enable_high(o_node_phys_enable_high));
    remote_node_model i_node (.i_clk(i_clk), .o_req_valid(i_req_valid), .o_req_src_id(i_req_src_id),
        .o_req_async_ok(i_req_async_ok));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus cycle; strobes stay as given until the next call
    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        i_wr    <= w;
        i_rd    <= r;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask
    // Write, then track the filter words locally
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
        case (a)
            OFF_FILT_HIGH_SET: hi = hi | d;
            OFF_FILT_HIGH_CLR: hi = hi & ~d;
            OFF_FILT_LOW_SET:  lo = lo | d;
            OFF_FILT_LOW_CLR:  lo = lo & ~d;
            OFF_ROUTE_CONTROL: lb = d[9:0];
            default: ;
        endcase
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, 1'b1, a, 32'h00000000);
        #1;
        chk("rdata", o_rdata, e);
    endtask
    // Outcome {phys, async, drop, valid} from the tracked words
    function automatic logic [3:0] expv(input logic [9:0] b, input logic [5:0] n, input logic ok);
        logic en;
        en = n[5] ? (n != 6'h3F && hi[n[4:0]]) : lo[n[4:0]];
        if (b != lb) return hi[REMOTE_BUS_BIT] ? 4'h9 : 4'h3;
        if (!ok) return 4'h3;
        return en ? 4'h9 : 4'h5;
    endfunction
    // Expectation fixed before the request so a racing write cannot leak in
    task automatic route(input logic [9:0] b, input logic [5:0] n, input logic ok);
        logic [3:0] e;
        e = expv(b, n, ok);
        i_node.send(b, n, ok);
        #1;
        chk("route", {28'h0, o_route_phys, o_route_async, o_route_drop, o_route_valid}, {28'h0, e});
        chk("route_src", {16'h0, o_route_src_id}, {16'h0, b, n});
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, far above the roughly 110 cycles of the sequence
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        {i_clk, i_rst_n, i_wr, i_rd, i_addr, i_wdata, lo, hi} = '0;
        {mismatches, samples_checked, cycles} = '0;
        lb = LOCAL_BUS_RESET;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(OFF_FILT_LOW_SET, FILT_LOW_RESET);
        rd(OFF_FILT_HIGH_CLR, FILT_HIGH_RESET);
        wr(OFF_FILT_LOW_SET, 32'h80000021);
        rd(OFF_FILT_LOW_CLR, 32'h80000021);
        wr(OFF_FILT_LOW_CLR, 32'h00000001);
        rd(OFF_FILT_LOW_SET, 32'h80000020);
        wr(OFF_FILT_HIGH_SET, 32'h40040001);
        rd(OFF_FILT_HIGH_CLR, 32'h40040001);
        wr(OFF_UPPER_BOUND, 32'hFFFFFFFF);
        rd(OFF_UPPER_BOUND, UPPER_BOUND_VALUE);
        rd(12'h1F0, UNMAPPED_READ);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000);
        chk("low_port", o_node_phys_enable_low, 32'h80000020);
        // Every node on the local bus, back to back
        for (int n = 0; n < 64; n++) route(LOCAL_BUS_RESET, n[5:0], 1'b1);
        route(LOCAL_BUS_RESET, 6'h05, 1'b0);
        route(10'h001, 6'h05, 1'b1);
        i_node.idle();
        wr(OFF_FILT_HIGH_SET, 32'h80000000);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000);
        route(10'h001, 6'h00, 1'b1);
        i_node.idle();
        wr(OFF_FILT_HIGH_CLR, 32'h80000000);
        wr(OFF_ROUTE_CONTROL, 32'h00000005);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000);
        route(10'h005, 6'h05, 1'b1);
        route(LOCAL_BUS_RESET, 6'h05, 1'b1);
        i_node.idle();
        // A write in the same cycle as a request leaves that request alone
        fork
            wr(OFF_FILT_LOW_SET, 32'h00000001);
            route(10'h005, 6'h00, 1'b1);
        join
        // Release the request strobe and zero the counters, then one request must count once as physical
        fork
            wr(OFF_ROUTE_STATUS, 32'h00000000);
            i_node.idle();
        join
        fork
            bus(1'b0, 1'b0, 12'h000, 32'h00000000);
            route(10'h005, 6'h00, 1'b1);
        join
        i_node.idle();
        rd(OFF_ROUTE_STATUS, 32'h00000001);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000);
        // Reset in mid-run clears what software set
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        {lo, hi} = '0;
        lb = LOCAL_BUS_RESET;
        rd(OFF_FILT_LOW_CLR, FILT_LOW_RESET);
        rd(OFF_FILT_HIGH_SET, FILT_HIGH_RESET);
        rd(OFF_ROUTE_CONTROL, {22'h0, LOCAL_BUS_RESET});
        rd(OFF_ROUTE_STATUS, 32'h00000000);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000);
        summarize();
    end
endmodule
bind physical_request_node_filter phys_filter_props i_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_req_valid(i_req_valid), .i_req_src_id(i_req_src_id), .i_req_async_ok(i_req_async_ok),
    .o_route_valid(o_route_valid), .o_route_phys(o_route_phys), .o_route_async(o_route_async),
    .o_route_drop(o_route_drop), .o_route_src_id(o_route_src_id),
    .o_node_phys_enable_low(o_node_phys_enable_low), .o_node_phys_enable_high(o_node_phys_enable_high));
